// ===== shared/nfcsm_pkg.sv
// Package with command codes, timing counts and carrier types for the host.
package nfcsm_pkg;
  // ****************************************************************
  // Bus widths and command codes
  // ****************************************************************
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam logic [11:0] UNLOCK_ADDR_1 = 12'h555;
  localparam logic [11:0] UNLOCK_ADDR_2 = 12'h2AA;
  localparam logic [7:0]  UNLOCK_DATA_1 = 8'hAA;
  localparam logic [7:0]  UNLOCK_DATA_2 = 8'h55;
  localparam logic [7:0]  CMD_RESET     = 8'hF0;
  localparam logic [7:0]  CMD_IDENT     = 8'h90;
  localparam logic [7:0]  CMD_PROGRAM   = 8'hA0;
  localparam logic [7:0]  CMD_ERASE_SET = 8'h80;
  localparam logic [7:0]  CMD_CHIP_ERS  = 8'h10;
  localparam logic [7:0]  CMD_SECT_ERS  = 8'h30;
  localparam logic [7:0]  CMD_SUSPEND   = 8'hB0;
  localparam logic [7:0]  CMD_RESUME    = 8'h30;
  localparam logic [7:0]  PROT_YES      = 8'h01;
  localparam logic [1:0]  ID_SEL_MANUF  = 2'b00;
  localparam logic [1:0]  ID_SEL_DEVICE = 2'b01;
  localparam logic [1:0]  ID_SEL_PROT   = 2'b10;
  localparam int          TOGGLE_BIT    = 6;

  // ****************************************************************
  // Strobe timing, nanoseconds and cycles of the 100 ns clock
  // ****************************************************************
  localparam int CLK_NS       = 100;
  localparam int STROBE_NS    = 200;
  localparam int SETUP_NS     = 100;
  localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC    = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
  localparam logic [3:0] SETUP_CNT  = 4'(SETUP_CYC);

  // ****************************************************************
  // Operation codes issued by the user side
  // ****************************************************************
  typedef enum logic [3:0] {
    NFCSM_OP_READ     = 4'h0,
    NFCSM_OP_RESET    = 4'h1,
    NFCSM_OP_IDENT    = 4'h2,
    NFCSM_OP_PROGRAM  = 4'h3,
    NFCSM_OP_CHIP_ERS = 4'h4,
    NFCSM_OP_SECT_ERS = 4'h5,
    NFCSM_OP_SUSPEND  = 4'h6,
    NFCSM_OP_RESUME   = 4'h7
  } nfcsm_op_t;

  typedef struct packed {
    nfcsm_op_t               op;
    logic [ADDR_W-1:0]       addr;
    logic [DATA_W-1:0]       data;
  } nfcsm_req_t;

  // One bus cycle handed to the strobe engine.
  typedef struct packed {
    logic                    write;
    logic [ADDR_W-1:0]       addr;
    logic [DATA_W-1:0]       data;
  } nfcsm_cyc_t;

  // Pins toward the flash.
  typedef struct packed {
    logic                    chipSelN;
    logic                    outGateN;
    logic                    writeStrN;
    logic                    resetN;
    logic [ADDR_W-1:0]       addr;
    logic [DATA_W-1:0]       dataOut;
    logic                    dataOe;
  } nfcsm_pins_t;
endpackage

// ===== logic/nfcsm_bus_cycle.sv
// Strobe engine that runs one read or write cycle on the flash pins.
`timescale 1ns/100ps
module nfcsm_bus_cycle (
  // Clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          nrst,
  // Cycle request
  input  wire logic                          cycValid,
  input  wire nfcsm_pkg::nfcsm_cyc_t         cyc,
  output logic                               cycReady,
  output logic                               cycDone,
  output logic [nfcsm_pkg::DATA_W-1:0]       cycRdata,
  // Pins
  output nfcsm_pkg::nfcsm_pins_t             pins,
  input  wire logic [nfcsm_pkg::DATA_W-1:0]  dataIn
);
  import nfcsm_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [3:0] {
    BC_IDLE  = 4'b0001,
    BC_SETUP = 4'b0010,
    BC_STRB  = 4'b0100,
    BC_HOLD  = 4'b1000
  } nfcsm_bc_st_t;

  typedef struct packed {
    nfcsm_bc_st_t            st;
    logic [3:0]              cnt;
    logic                    write;
    logic                    done;
    logic [DATA_W-1:0]       rdata;
    nfcsm_pins_t             pins;
  } nfcsm_bc_t;

  nfcsm_bc_t bc_ff;
  nfcsm_bc_t nxt_bc;
  logic [DATA_W-1:0] dataSync1_ff;
  logic [DATA_W-1:0] dataSync2_ff;

  // Read data is synchronised before the engine samples it.
  always_ff @(posedge ref_clk) begin
    dataSync1_ff <= dataIn;
    dataSync2_ff <= dataSync1_ff;
  end

  always_comb begin
    nxt_bc = bc_ff;
    nxt_bc.done = 1'b0;
    case (bc_ff.st)
      BC_IDLE: begin
        if (cycValid) begin
          // Address is set up before the strobes fall.
          nxt_bc.st = BC_SETUP;
          nxt_bc.cnt = SETUP_CNT;
          nxt_bc.write = cyc.write;
          nxt_bc.pins.addr = cyc.addr;
          nxt_bc.pins.dataOut = cyc.data;
          nxt_bc.pins.dataOe = cyc.write;
        end
      end
      BC_SETUP: begin
        nxt_bc.cnt = bc_ff.cnt - 4'h1;
        if (bc_ff.cnt == 4'h1) begin
          // Chip select low with output gate high is a write. see R19
          nxt_bc.st = BC_STRB;
          nxt_bc.cnt = STROBE_CNT + 4'h2;
          nxt_bc.pins.chipSelN = 1'b0;
          nxt_bc.pins.writeStrN = ~bc_ff.write;
          nxt_bc.pins.outGateN = bc_ff.write;
        end
      end
      BC_STRB: begin
        nxt_bc.cnt = bc_ff.cnt - 4'h1;
        if (bc_ff.cnt == 4'h1) begin
          // Write strobe rises with data still stable. see R01
          nxt_bc.st = BC_HOLD;
          nxt_bc.rdata = dataSync2_ff;
          nxt_bc.pins.chipSelN = 1'b1;
          nxt_bc.pins.writeStrN = 1'b1;
          nxt_bc.pins.outGateN = 1'b1;
        end
      end
      BC_HOLD: begin
        nxt_bc.st = BC_IDLE;
        nxt_bc.done = 1'b1;
        nxt_bc.pins.dataOe = 1'b0;
      end
      default: nxt_bc.st = BC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      bc_ff <= '{st: BC_IDLE, cnt: 4'h0, write: 1'b0, done: 1'b0,
                 rdata: '0,
                 pins: '{chipSelN: 1'b1, outGateN: 1'b1, writeStrN: 1'b1,
                         resetN: 1'b1, addr: '0, dataOut: '0,
                         dataOe: 1'b0}};
    end else begin
      bc_ff <= nxt_bc;
    end
  end

  assign cycReady = (bc_ff.st == BC_IDLE);
  assign cycDone  = bc_ff.done;
  assign cycRdata = bc_ff.rdata;
  assign pins     = bc_ff.pins;
endmodule // nfcsm_bus_cycle

// ===== logic/nfcsm_host.sv
// Host controller that issues flash command sequences over the pins.
//
// Operation
// R01: Address on falling strobe, data on rising.
// R02: Program running ignores all command writes.
// R03: Sector erase running accepts only suspend.
// R04: After suspend, device stays in read mode.
// R05: Finished algorithm accepts full command set again.
// R06: Device times and verifies erase itself.
// R07: Toggle bit changes each read during erase.
// R08: Bad sequence returns device to read.
// R09: Suspend and resume valid only in erase.
// R10: Host puts 555/2AA on low twelve bits.
// R11: Identifier sequence then A1A0 selects code.
// R12: Identifier read A1 high gives protection.
// R13: High-voltage identifier method is for programmers.
// R14: Protection verify drives sector on top bits.
// R15: Program is unlock, A0, then data write.
// R16: Erase is six writes ending 10 or 30.
// R17: Hardware reset aborts and returns to read.
// R18: Device starts in read-array mode.
// R19: Read, write and float by strobe levels.
// R20: Reset code ends identifier mode.
`timescale 1ns/100ps
module nfcsm_host (
  // Clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          nrst,
  // User request
  input  wire logic                          reqValid,
  input  wire nfcsm_pkg::nfcsm_req_t         req,
  input  wire logic                          hwResetReq,
  output logic                               reqReady,
  output logic                               respValid,
  output logic [nfcsm_pkg::DATA_W-1:0]       respData,
  output logic                               busy,
  output logic                               eraseSuspended,
  // Flash pins
  output nfcsm_pkg::nfcsm_pins_t             flashPins,
  input  wire logic [nfcsm_pkg::DATA_W-1:0]  flashDataIn
);
  import nfcsm_pkg::*;

  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  typedef enum logic [5:0] {
    HS_IDLE  = 6'b000001,
    HS_ISSUE = 6'b000010,
    HS_WAIT  = 6'b000100,
    HS_POLL  = 6'b001000,
    HS_RST   = 6'b010000,
    HS_RESP  = 6'b100000
  } nfcsm_hs_st_t;
  typedef enum logic [1:0] {
    MD_READ  = 2'b00,
    MD_IDENT = 2'b01,
    MD_PROG  = 2'b10,
    MD_ERASE = 2'b11
  } nfcsm_mode_t;
  typedef struct packed {
    nfcsm_hs_st_t            st;
    nfcsm_mode_t             mode;
    logic                    suspended;
    logic [2:0]              idx;
    logic [2:0]              last;
    nfcsm_req_t              req;
    logic                    pollHave;
    logic [DATA_W-1:0]       pollPrev;
    logic [3:0]              rstCnt;
    logic                    cycValid;
    nfcsm_cyc_t              cyc;
    logic                    respValid;
    logic [DATA_W-1:0]       respData;
    logic                    reqReady;
    logic                    resetN;
    logic                    busy;
  } nfcsm_host_t;

  nfcsm_host_t hs_ff;
  nfcsm_host_t nxt_hs;
  logic        cycReady;
  logic        cycDone;
  logic [DATA_W-1:0] cycRdata;
  nfcsm_pins_t busPins;

  // ****************************************************************
  // Command step table
  // ****************************************************************
  // Returns the bus cycle for step idx of an operation.
  function automatic nfcsm_cyc_t step_cyc(input nfcsm_req_t r,
                                          input logic [2:0] idx);
    nfcsm_cyc_t c;
    c.write = 1'b1;
    c.addr = {{(ADDR_W-12){1'b0}}, UNLOCK_ADDR_1};  // see R10
    c.data = UNLOCK_DATA_1;
    case (idx)
      3'd0: c.data = UNLOCK_DATA_1;
      3'd1: begin
        c.addr = {{(ADDR_W-12){1'b0}}, UNLOCK_ADDR_2};
        c.data = UNLOCK_DATA_2;
      end
      3'd2: begin
        case (r.op)
          NFCSM_OP_IDENT:   c.data = CMD_IDENT;    // see R11
          NFCSM_OP_PROGRAM: c.data = CMD_PROGRAM;  // see R15
          default:          c.data = CMD_ERASE_SET; // see R16
        endcase
      end
      3'd3: begin
        if (r.op == NFCSM_OP_PROGRAM) begin
          c.addr = r.addr;
          c.data = r.data;
        end else begin
          c.data = UNLOCK_DATA_1;
        end
      end
      3'd4: begin
        c.addr = {{(ADDR_W-12){1'b0}}, UNLOCK_ADDR_2};
        c.data = UNLOCK_DATA_2;
      end
      default: begin
        if (r.op == NFCSM_OP_SECT_ERS) begin
          c.addr = r.addr;  // see R14
          c.data = CMD_SECT_ERS;
        end else begin
          c.data = CMD_CHIP_ERS;
        end
      end
    endcase
    return c;
  endfunction

  // Decides whether the device would accept this operation now.
  function automatic logic op_allowed(input nfcsm_op_t op,
                                      input nfcsm_mode_t md,
                                      input logic susp);
    logic ok;
    ok = 1'b1;
    if (md == MD_PROG) begin
      ok = 1'b0;                                   // see R02
    end else if (md == MD_ERASE && !susp) begin
      ok = (op == NFCSM_OP_SUSPEND);               // see R03
    end else if (op == NFCSM_OP_RESUME) begin
      ok = susp;                                   // see R09
    end else if (op == NFCSM_OP_SUSPEND) begin
      ok = 1'b0;                                   // see R09
    end
    return ok;
  endfunction

  always_comb begin
    nxt_hs = hs_ff;
    nxt_hs.respValid = 1'b0;
    nxt_hs.cycValid = 1'b0;
    nxt_hs.reqReady = 1'b0;
    case (hs_ff.st)
      HS_IDLE: begin
        nxt_hs.reqReady = 1'b1;
        if (hwResetReq) begin
          nxt_hs.st = HS_RST;
          nxt_hs.rstCnt = STROBE_CNT;
          nxt_hs.resetN = 1'b0;
          nxt_hs.reqReady = 1'b0;
        end else if (reqValid && hs_ff.reqReady) begin
          nxt_hs.reqReady = 1'b0;
          nxt_hs.req = req;
          nxt_hs.idx = 3'd0;
          nxt_hs.st = HS_ISSUE;
          case (req.op)
            NFCSM_OP_READ: begin // see R11 R12
              nxt_hs.last = 3'd0;
              nxt_hs.cyc = '{write: 1'b0, addr: req.addr, data: '0};
            end
            NFCSM_OP_RESET, NFCSM_OP_SUSPEND, NFCSM_OP_RESUME: begin
              nxt_hs.last = 3'd0;
              nxt_hs.cyc.write = 1'b1;
              nxt_hs.cyc.addr = req.addr;
              nxt_hs.cyc.data = (req.op == NFCSM_OP_RESET) ? CMD_RESET :
                (req.op == NFCSM_OP_SUSPEND) ? CMD_SUSPEND : CMD_RESUME;
            end
            NFCSM_OP_IDENT: nxt_hs.last = 3'd2;
            NFCSM_OP_PROGRAM: nxt_hs.last = 3'd3;
            default: nxt_hs.last = 3'd5;
          endcase
          if (req.op inside {NFCSM_OP_IDENT, NFCSM_OP_PROGRAM,
                             NFCSM_OP_CHIP_ERS, NFCSM_OP_SECT_ERS}) begin
            nxt_hs.cyc = step_cyc(req, 3'd0);
          end
          // A refused command is not sent; the answer is zero at once.
          if (req.op != NFCSM_OP_READ &&
              !op_allowed(req.op, hs_ff.mode, hs_ff.suspended)) begin
            nxt_hs.st = HS_RESP;
            nxt_hs.respData = '0;
          end
        end
      end
      HS_ISSUE: begin
        nxt_hs.cycValid = 1'b1;
        if (cycReady && hs_ff.cycValid) begin
          nxt_hs.cycValid = 1'b0;
          nxt_hs.st = HS_WAIT;
        end
      end
      HS_WAIT: begin
        if (cycDone) begin
          if (hs_ff.idx != hs_ff.last) begin
            nxt_hs.idx = hs_ff.idx + 3'd1;
            nxt_hs.cyc = step_cyc(hs_ff.req, hs_ff.idx + 3'd1);
            nxt_hs.st = HS_ISSUE;
          end else begin
            nxt_hs.respData = cycRdata;
            nxt_hs.st = HS_RESP;
            case (hs_ff.req.op)
              NFCSM_OP_RESET: nxt_hs.mode = MD_READ;      // see R20 R08
              NFCSM_OP_IDENT: nxt_hs.mode = MD_IDENT;     // see R11
              NFCSM_OP_PROGRAM: nxt_hs.mode = MD_PROG;
              NFCSM_OP_CHIP_ERS, NFCSM_OP_SECT_ERS:
                nxt_hs.mode = MD_ERASE;                   // see R06
              NFCSM_OP_SUSPEND: nxt_hs.suspended = 1'b1;  // see R04
              NFCSM_OP_RESUME: nxt_hs.suspended = 1'b0;
              default: ;
            endcase
            if (hs_ff.req.op inside {NFCSM_OP_PROGRAM, NFCSM_OP_CHIP_ERS,
                                     NFCSM_OP_SECT_ERS, NFCSM_OP_RESUME})
            begin
              nxt_hs.st = HS_POLL;
              nxt_hs.pollHave = 1'b0;
              nxt_hs.cyc = '{write: 1'b0, addr: '0, data: '0};
            end
          end
        end
      end
      HS_POLL: begin
        // Reads until the toggle bit stands still on two reads. see R07
        nxt_hs.cycValid = ~hs_ff.cycValid & cycReady & ~cycDone;
        if (cycDone) begin
          nxt_hs.pollHave = 1'b1;
          nxt_hs.pollPrev = cycRdata;
          if (hs_ff.pollHave &&
              cycRdata[TOGGLE_BIT] == hs_ff.pollPrev[TOGGLE_BIT]) begin
            nxt_hs.mode = MD_READ;                        // see R05
            nxt_hs.respData = cycRdata;
            nxt_hs.st = HS_RESP;
            nxt_hs.cycValid = 1'b0;
          end
        end
        if (hwResetReq) begin
          nxt_hs.st = HS_RST;
          nxt_hs.rstCnt = STROBE_CNT;
          nxt_hs.resetN = 1'b0;
          nxt_hs.cycValid = 1'b0;
        end
      end
      HS_RST: begin
        // Reset pulse held for the minimum width. see R17
        nxt_hs.rstCnt = hs_ff.rstCnt - 4'h1;
        if (hs_ff.rstCnt == 4'h1) begin
          nxt_hs.resetN = 1'b1;
          nxt_hs.mode = MD_READ;                          // see R18
          nxt_hs.suspended = 1'b0;
          nxt_hs.st = HS_IDLE;
        end
      end
      HS_RESP: begin
        nxt_hs.respValid = 1'b1;
        nxt_hs.st = HS_IDLE;
      end
      default: nxt_hs.st = HS_IDLE;
    endcase
    nxt_hs.busy = (nxt_hs.mode == MD_PROG) ||
                  (nxt_hs.mode == MD_ERASE && !nxt_hs.suspended);
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      hs_ff <= '{st: HS_IDLE, mode: MD_READ, suspended: 1'b0,
                 idx: 3'd0, last: 3'd0, req: '0, pollHave: 1'b0,
                 pollPrev: '0, rstCnt: 4'h0, cycValid: 1'b0, cyc: '0,
                 respValid: 1'b0, respData: '0, reqReady: 1'b0,
                 resetN: 1'b1, busy: 1'b0};
    end else begin
      hs_ff <= nxt_hs;
    end
  end

  nfcsm_bus_cycle u_bus (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .cycValid (hs_ff.cycValid),
    .cyc      (hs_ff.cyc),
    .cycReady (cycReady),
    .cycDone  (cycDone),
    .cycRdata (cycRdata),
    .pins     (busPins),
    .dataIn   (flashDataIn)
  );

  always_comb begin
    flashPins = busPins;
    flashPins.resetN = hs_ff.resetN;
  end

  assign reqReady       = hs_ff.reqReady;
  assign respValid      = hs_ff.respValid;
  assign respData       = hs_ff.respData;
  assign busy           = hs_ff.busy;
  assign eraseSuspended = hs_ff.suspended;
endmodule // nfcsm_host

// ===== testbench/nfcsm_host_sva.sv
// Concurrent checks on the ports of the flash host controller.
`timescale 1ns/100ps
module nfcsm_host_sva (
  // Clock and reset
  input wire logic                   ref_clk,
  input wire logic                   nrst,
  // User side
  input wire logic                   reqValid,
  input wire nfcsm_pkg::nfcsm_req_t  req,
  input wire logic                   hwResetReq,
  input wire logic                   reqReady,
  input wire logic                   respValid,
  input wire logic [7:0]             respData,
  input wire logic                   busy,
  input wire logic                   eraseSuspended,
  // Flash pins
  input wire nfcsm_pkg::nfcsm_pins_t flashPins,
  input wire logic [7:0]             flashDataIn
);
  import nfcsm_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_no_rw_clash: assert property (
    flashPins.outGateN || flashPins.writeStrN)
    else $error("read and write strobes low together");
  a_write_drives: assert property (
    !flashPins.writeStrN |-> flashPins.dataOe && !flashPins.chipSelN)
    else $error("write strobe without driven data");
  a_read_floats: assert property (
    !flashPins.outGateN |-> !flashPins.dataOe && !flashPins.chipSelN)
    else $error("data driven during a read");
  a_write_width: assert property (
    $fell(flashPins.writeStrN) |->
      (!flashPins.writeStrN)[*4] ##1 flashPins.writeStrN)
    else $error("write strobe width wrong");
  a_write_hold: assert property (
    !flashPins.writeStrN |=>
      $stable(flashPins.addr) && $stable(flashPins.dataOut))
    else $error("address or data moved around a write");
  a_bus_release: assert property (
    $rose(flashPins.writeStrN) |=> !flashPins.dataOe)
    else $error("data bus not released after write");
  a_reset_pulse: assert property (
    $fell(flashPins.resetN) |->
      (!flashPins.resetN)[*2] ##1 flashPins.resetN)
    else $error("reset pulse width wrong");
  a_refuse_resp: assert property (
    (reqValid && reqReady && !busy && req.op == NFCSM_OP_SUSPEND) |->
      ##[1:3] (respValid && respData == 8'h00))
    else $error("refused suspend not answered with zero");
  a_refuse_quiet: assert property (
    (reqValid && reqReady && !busy && req.op == NFCSM_OP_SUSPEND) |->
      flashPins.chipSelN[*4])
    else $error("refused suspend moved the pins");
endmodule // nfcsm_host_sva
bind nfcsm_host nfcsm_host_sva i_sva (.ref_clk(ref_clk), .nrst(nrst),
  .reqValid(reqValid), .req(req), .hwResetReq(hwResetReq),
  .reqReady(reqReady), .respValid(respValid), .respData(respData),
  .busy(busy), .eraseSuspended(eraseSuspended),
  .flashPins(flashPins), .flashDataIn(flashDataIn));

// ===== testbench/nfcsm_flash_model.sv
// Behavioural flash device answering the host's strobe cycles.
`timescale 1ns/100ps
module nfcsm_flash_model #(
  parameter logic [7:0] MANUF_CODE = 8'h3C, // Arbitrary value.
  parameter logic [7:0] DEV_CODE   = 8'h5D, // Arbitrary value.
  parameter logic [5:0] PROT_SECT  = 6'h05,
  parameter int         PROG_READS = 3,
  parameter int         ERS_READS  = 5
) (
  // Flash pins
  input  wire nfcsm_pkg::nfcsm_pins_t pins,
  output logic [7:0]                  dataOut,
  // Observation
  output logic [2:0]                  mode = 3'd0,
  output int                          wrCount = 0,
  output logic [18:0]                 lastAddr,
  output logic [7:0]                  lastData
);
  import nfcsm_pkg::*;
  logic [2:0]  step_ff = 3'd0;
  logic [18:0] latAddr_ff;
  logic [18:0] progAddr_ff;
  logic [7:0]  progData_ff;
  logic [7:0]  rdVal_ff = 8'h00;
  logic        progOk_ff = 1'b0;
  logic        erased_ff = 1'b0;
  logic        sect_ff = 1'b0;
  logic        tgl_ff = 1'b0;
  logic        wrOpen_ff = 1'b0;
  int          busyLeft_ff = 0;
  wire wrStrN = pins.chipSelN | pins.writeStrN;
  wire rdStrN = pins.chipSelN | pins.outGateN;
  // A released bus shows the inverse of the last byte, never a held value.
  assign dataOut = (!rdStrN && pins.resetN) ? rdVal_ff : ~rdVal_ff;

  task automatic command(input logic [18:0] a, input logic [7:0] d);
    logic u1, u2, ok;
    u1 = a[11:0] == UNLOCK_ADDR_1 && d == UNLOCK_DATA_1;
    u2 = a[11:0] == UNLOCK_ADDR_2 && d == UNLOCK_DATA_2;
    case (step_ff)
      3'd0, 3'd4: ok = u1;
      3'd1, 3'd5: ok = u2;
      3'd2: ok = a[11:0] == UNLOCK_ADDR_1 &&
                 d inside {CMD_IDENT, CMD_PROGRAM, CMD_ERASE_SET};
      3'd6: ok = d == CMD_SECT_ERS ||
                 (d == CMD_CHIP_ERS && a[11:0] == UNLOCK_ADDR_1);
      default: ok = 1'b1;
    endcase
    if (!ok) begin
      step_ff = 3'd0;
      mode = 3'd0;
    end else if (step_ff == 3'd2) begin
      step_ff = d == CMD_PROGRAM ? 3'd3 : (d == CMD_ERASE_SET ? 3'd4 : 3'd0);
      if (d == CMD_IDENT) mode = 3'd1;
    end else if (step_ff == 3'd3) begin
      progAddr_ff = a;
      progData_ff = d;
      progOk_ff = 1'b1;
      mode = 3'd2;
      busyLeft_ff = PROG_READS;
      step_ff = 3'd0;
    end else if (step_ff == 3'd6) begin
      sect_ff = d == CMD_SECT_ERS;
      erased_ff = 1'b1;
      progOk_ff = 1'b0;
      mode = 3'd3;
      busyLeft_ff = ERS_READS;
      step_ff = 3'd0;
    end else begin
      step_ff = step_ff + 3'd1;
    end
  endtask

  always @(negedge pins.resetN) begin
    mode = 3'd0;
    step_ff = 3'd0;
  end
  always @(negedge wrStrN) begin
    latAddr_ff = pins.addr;
    wrOpen_ff = pins.resetN;
  end
  always @(posedge wrStrN) if (wrOpen_ff) begin
    wrOpen_ff = 1'b0;
    wrCount++;
    lastAddr = latAddr_ff;
    lastData = pins.dataOut;
    if (mode == 3'd3 && sect_ff && pins.dataOut == CMD_SUSPEND)
      mode = 3'd4;
    else if (mode == 3'd4 && pins.dataOut == CMD_RESUME)
      mode = 3'd3;
    else if (mode < 3'd2)
      command(latAddr_ff, pins.dataOut);
  end
  always @(negedge rdStrN) if (pins.resetN) begin
    if (mode == 3'd2 || mode == 3'd3) begin
      tgl_ff = ~tgl_ff;
      rdVal_ff = 8'h00;
      rdVal_ff[TOGGLE_BIT] = tgl_ff;
      if (busyLeft_ff == 0) mode = 3'd0;
      else busyLeft_ff--;
    end else if (mode == 3'd1) begin
      case (pins.addr[1:0])
        2'b00: rdVal_ff = MANUF_CODE;
        2'b01: rdVal_ff = DEV_CODE;
        2'b10: rdVal_ff = {7'h00, pins.addr[18:13] == PROT_SECT};
        default: rdVal_ff = 8'h00;
      endcase
    end else if (progOk_ff && pins.addr == progAddr_ff) begin
      rdVal_ff = progData_ff;
    end else begin
      rdVal_ff = erased_ff ? 8'hFF : pins.addr[7:0] ^ 8'h5A;
    end
  end
endmodule // nfcsm_flash_model

// ===== testbench/nfcsm_tb.sv
// Self-checking bench for the flash host controller.
`timescale 1ns/100ps
module testbench;
  import nfcsm_pkg::*;
  localparam logic [7:0]  ID_MANUF = 8'h3C; // Arbitrary value.
  localparam logic [7:0]  ID_DEV   = 8'h5D; // Arbitrary value.
  localparam logic [5:0]  PROT     = 6'h05;
  localparam logic [18:0] PA       = 19'h2_3456;
  logic        ref_clk;
  logic        nrst;
  logic        reqValid;
  logic        hwResetReq;
  nfcsm_req_t  req;
  logic        reqReady;
  logic        respValid;
  logic        busy;
  logic        eraseSuspended;
  logic [7:0]  respData;
  logic [7:0]  flashDataIn;
  logic [7:0]  lastData;
  logic [7:0]  rd;
  nfcsm_pins_t flashPins;
  logic [2:0]  mode;
  logic [18:0] lastAddr;
  int          wrCount;
  int          w0;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  nfcsm_host i_dut (.ref_clk(ref_clk), .nrst(nrst), .reqValid(reqValid),
    .req(req), .hwResetReq(hwResetReq), .reqReady(reqReady),
    .respValid(respValid), .respData(respData), .busy(busy),
    .eraseSuspended(eraseSuspended), .flashPins(flashPins),
    .flashDataIn(flashDataIn));
  nfcsm_flash_model #(.MANUF_CODE(ID_MANUF), .DEV_CODE(ID_DEV),
    .PROT_SECT(PROT)) i_flash (.pins(flashPins), .dataOut(flashDataIn),
    .mode(mode), .wrCount(wrCount), .lastAddr(lastAddr),
    .lastData(lastData));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 50000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic summarize();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkState(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic doReq(input nfcsm_op_t op, input logic [18:0] a,
                       input logic [7:0] d, output logic [7:0] r);
    int n;
    @(negedge ref_clk);
    req = '{op: op, addr: a, data: d};
    reqValid = 1'b1;
    n = 0;
    while (reqReady !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    reqValid = 1'b0;
    while (respValid !== 1'b1) @(negedge ref_clk);
    r = respData;
  endtask

  task automatic identify();
    w0 = wrCount;
    doReq(NFCSM_OP_IDENT, 19'h0_0000, 8'h00, rd);
    chkState(wrCount - w0, 3);
    chkByte(lastData, CMD_IDENT);
    chkState(32'(lastAddr[11:0]), 32'h555);
    doReq(NFCSM_OP_READ, 19'h3_FFFC, 8'h00, rd);
    chkByte(rd, ID_MANUF);
    doReq(NFCSM_OP_READ, 19'h1_5551, 8'h00, rd);
    chkByte(rd, ID_DEV);
    doReq(NFCSM_OP_READ, {PROT, 13'h0002}, 8'h00, rd);
    chkByte(rd, 8'h01);
    doReq(NFCSM_OP_READ, {6'h06, 13'h1FFE}, 8'h00, rd);
    chkByte(rd, 8'h00);
    doReq(NFCSM_OP_RESET, 19'h0_0000, 8'h00, rd);
    chkState(32'(mode), 0);
  endtask
  task automatic hwPulse();
    int n;
    doReq(NFCSM_OP_IDENT, 19'h0_0000, 8'h00, rd);
    chkState(32'(mode), 1);
    @(negedge ref_clk);
    hwResetReq = 1'b1;
    n = 0;
    while (flashPins.resetN !== 1'b0 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    hwResetReq = 1'b0;
    chkState(32'(mode), 0);
    doReq(NFCSM_OP_READ, 19'h0_0123, 8'h00, rd);
    chkByte(rd, 8'h79);
  endtask
  task automatic progByte();
    w0 = wrCount;
    doReq(NFCSM_OP_PROGRAM, PA, 8'h96, rd);
    chkState(wrCount - w0, 4);
    chkState(32'(lastAddr), 32'(PA));
    chkByte(lastData, 8'h96);
    chkState(32'(mode), 0);
    doReq(NFCSM_OP_READ, PA, 8'h00, rd);
    chkByte(rd, 8'h96);
  endtask
  task automatic eraseAll();
    for (int i = 0; i < 2; i++) begin
      w0 = wrCount;
      doReq(i ? NFCSM_OP_SECT_ERS : NFCSM_OP_CHIP_ERS, {PROT, 13'h0000},
            8'h00, rd);
      chkState(wrCount - w0, 6);
      chkByte(lastData, i ? CMD_SECT_ERS : CMD_CHIP_ERS);
      chkState(i ? 32'(lastAddr[18:13]) : 32'(lastAddr[11:0]),
               i ? 32'(PROT) : 32'h555);
      chkState(32'({busy, eraseSuspended}), 32'h0);
      chkState(32'(mode), 0);
      doReq(NFCSM_OP_READ, PA, 8'h00, rd);
      chkByte(rd, 8'hFF);
    end
  endtask
  task automatic refuseCmds();
    for (int i = 0; i < 2; i++) begin
      w0 = wrCount;
      doReq(i ? NFCSM_OP_RESUME : NFCSM_OP_SUSPEND, 19'h0_0000, 8'h00, rd);
      chkByte(rd, 8'h00);
      chkState(wrCount - w0, 0);
    end
  endtask

  initial begin
    nrst = 1'b0;
    reqValid = 1'b0;
    hwResetReq = 1'b0;
    req = '0;
    repeat (5) @(negedge ref_clk);
    nrst = 1'b1;
    doReq(NFCSM_OP_READ, 19'h0_0123, 8'h00, rd);
    chkByte(rd, 8'h79);
    identify();
    hwPulse();
    progByte();
    eraseAll();
    refuseCmds();
    summarize();
  end
endmodule // testbench
